// [logic/dfdm_map.vh]
// Register map, field positions, reset values and timing constants for the DTC manager
// Operation
// R01: Lamp setting: 0 off, 1 on, 2 blink
// R02: Blink toggle period set in milliseconds
// R03: Diagnostics-off and empty-DM1 switches reset disabled
// R04: Supply under/over voltage thresholds clamped 9..36
// R05: Undervoltage clears at threshold plus hysteresis
// R06: Overvoltage clears at threshold minus hysteresis
// R07: Over-temperature raised at or above threshold
// R08: Over-temperature clears at threshold minus hysteresis
// R09: Supply or heat fault disables outputs if optioned
// R10: CAN fault on timeout, cleared by receive
// R11: DTC reported only when generation flag set
// R12: Without DM11 latch, DTC drops with error
// R13: DM11 latch: clear on DM11 if absent
// R14: Generation flag default true only motor drive
// R15: Lamp code: protect, amber, red, malfunction
// R16: Failure mode 0..21 or 31
// R17: Activation delay; early release activates nothing
// R18: Separate clearing delay after input drops
// R19: Occurrence count increments on activation, saturates
`ifndef DFDM_MAP_VH
`define DFDM_MAP_VH

// ==========================================================================
// Register byte offsets
`define DFDM_OFF_CTRL      8'h00
`define DFDM_OFF_VOLT      8'h04
`define DFDM_OFF_TEMP      8'h08
`define DFDM_OFF_LED       8'h0c
`define DFDM_OFF_INT_STAT  8'h10
`define DFDM_OFF_INT_MASK  8'h14
`define DFDM_OFF_FAULT     8'h18
`define DFDM_OFF_CMD       8'h1c
`define DFDM_OFF_DTC_CFG   8'h20
`define DFDM_OFF_DTC_STAT  8'h40

// ==========================================================================
// Control and command register bits
`define DFDM_CTRL_DIAG_OFF   0
`define DFDM_CTRL_EMPTY_DM1  1
`define DFDM_CTRL_SUP_EN     2
`define DFDM_CTRL_TEMP_EN    3
`define DFDM_CTRL_PWR_SD     4
`define DFDM_CTRL_TEMP_SD    5
`define DFDM_CMD_DM11        0
`define DFDM_CMD_DM3         1

// ==========================================================================
// DTC configuration fields
`define DFDM_DTC_GEN         0
`define DFDM_DTC_DM11_ONLY   1
`define DFDM_DTC_LAMP_LSB    2
`define DFDM_DTC_FMI_LSB     4
`define DFDM_DTC_ON_LSB      16
`define DFDM_DTC_OFF_LSB     24

// ==========================================================================
// Encodings
`define DFDM_RESP_OFF        2'h0
`define DFDM_RESP_ON         2'h1
`define DFDM_RESP_BLINK      2'h2
`define DFDM_LAMP_PROTECT    2'h0
`define DFDM_LAMP_AMBER      2'h1
`define DFDM_LAMP_RED        2'h2
`define DFDM_LAMP_MIL        2'h3
`define DFDM_FMI_MAX         5'h15
`define DFDM_FMI_EXISTS      5'h1f
`define DFDM_V_MIN           8'h09
`define DFDM_V_MAX           8'h24
`define DFDM_OCC_MAX         7'h7f

// ==========================================================================
// Reset values
`define DFDM_CTRL_RST        32'h0000_0000
`define DFDM_VOLT_RST        32'h0001_200a
`define DFDM_TEMP_RST        32'h0000_0564
`define DFDM_LED_RST         32'h01f4_0000
`define DFDM_DTC_RST         32'h0000_01f0
`define DFDM_DTC_MOTOR_RST   32'h0000_01f5

// ==========================================================================
// Timing
`define DFDM_CLK_PERIOD_NS   4
`define DFDM_MS_NS           1000000
`define DFDM_MS_CYCLES       (`DFDM_MS_NS / `DFDM_CLK_PERIOD_NS)

`endif

// [logic/dfdm_top.v]
// Diagnostic supervision: lamps, supply/heat/CAN faults, DTC manager, APB slave
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "dfdm_map.vh"

module dfdm_top #(
  parameter MS_CYCLES = `DFDM_MS_CYCLES
) (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  // Measurements and fault sources
  input  wire [7:0]  supply_volts,
  input  wire [7:0]  temp_deg,
  input  wire        can_rx_timeout,
  input  wire        can_rx_msg,
  input  wire        motor_fault,
  input  wire        uin_fault,
  input  wire        enc_fault,
  // Network diagnostic commands
  input  wire        dm11_rx,
  input  wire        dm3_rx,
  // Outputs
  output reg  [2:0]  led_q,
  output reg         outputs_off_q,
  output reg  [5:0]  dtc_active_q,
  output reg         empty_dm1_q,
  output reg         irq_q
);

  localparam NCH = 6;
  localparam ST_IDLE  = 2'h0;
  localparam ST_PEND  = 2'h1;
  localparam ST_ACT   = 2'h2;
  localparam ST_CLR   = 2'h3;

  // ==========================================================================
  // Register storage
  reg  [31:0] ctrl_q;
  reg  [31:0] volt_q;
  reg  [31:0] temp_q;
  reg  [31:0] led_cfg_q;
  reg  [5:0]  int_stat_q;
  reg  [5:0]  int_mask_q;
  reg  [31:0] dtc_cfg_q [0:NCH-1];
  reg         dm11_cmd_q;
  reg         dm3_cmd_q;

  wire        acc     = psel & penable & pready_q;
  wire        wr_en   = acc & pwrite;
  wire        diag_off = ctrl_q[`DFDM_CTRL_DIAG_OFF];
  wire        dm11    = dm11_rx | dm11_cmd_q;
  wire        dm3     = dm3_rx | dm3_cmd_q;
  wire [5:0]  act_ev;
  wire [5:0]  act_lvl;
  wire [41:0] occ_all;

  // ==========================================================================
  // Threshold clamping to the legal supply window
  function [7:0] clamp_v;
    input [7:0] v;
    begin
      if (v < `DFDM_V_MIN)
        clamp_v = `DFDM_V_MIN;
      else if (v > `DFDM_V_MAX)
        clamp_v = `DFDM_V_MAX;
      else
        clamp_v = v;
    end
  endfunction

  wire [7:0] uv_thr = clamp_v(volt_q[7:0]);   // [R04]
  wire [7:0] ov_thr = clamp_v(volt_q[15:8]);  // [R04]
  wire [8:0] v_hys  = {1'b0, volt_q[23:16]};
  wire [8:0] t_hys  = {1'b0, temp_q[15:8]};
  wire [8:0] v_in   = {1'b0, supply_volts};
  wire [8:0] t_in   = {1'b0, temp_deg};

  // ==========================================================================
  // Supply, temperature and CAN fault flags
  reg        uv_q;
  reg        ov_q;
  reg        ot_q;
  reg        can_q;
  wire       sup_latch = dtc_cfg_q[0][`DFDM_DTC_DM11_ONLY];
  wire       uv_ok = v_in >= ({1'b0, uv_thr} + v_hys);      // [R05]
  wire       ov_ok = (v_in + v_hys) <= {1'b0, ov_thr};      // [R06]
  wire       sup_chk = ctrl_q[`DFDM_CTRL_SUP_EN] & ~diag_off;
  wire       tmp_chk = ctrl_q[`DFDM_CTRL_TEMP_EN] & ~diag_off;

  // Latched supply faults wait for DM11 so the DTC cannot flicker off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_q  <= 1'b0;
      ov_q  <= 1'b0;
      ot_q  <= 1'b0;
      can_q <= 1'b0;
    end else begin
      if (!sup_chk)
        uv_q <= 1'b0;
      else if (supply_volts < uv_thr)
        uv_q <= 1'b1;                                        // [R04]
      else if (uv_ok && (!sup_latch || dm11))
        uv_q <= 1'b0;                                        // [R05]
      if (!sup_chk)
        ov_q <= 1'b0;
      else if (supply_volts > ov_thr)
        ov_q <= 1'b1;                                        // [R04]
      else if (ov_ok && (!sup_latch || dm11))
        ov_q <= 1'b0;                                        // [R06]
      if (!tmp_chk)
        ot_q <= 1'b0;
      else if (temp_deg >= temp_q[7:0])
        ot_q <= 1'b1;                                        // [R07]
      else if ((t_in + t_hys) <= {1'b0, temp_q[7:0]})
        ot_q <= 1'b0;                                        // [R08]
      // Timeout wins if it meets a receive in the same cycle
      if (diag_off)
        can_q <= 1'b0;
      else if (can_rx_timeout)
        can_q <= 1'b1;                                       // [R10]
      else if (can_rx_msg)
        can_q <= 1'b0;                                       // [R10]
    end
  end

  wire       sup_f = uv_q | ov_q;
  wire [5:0] fault_lvl = {enc_fault, uin_fault, motor_fault, can_q, ot_q, sup_f};

  // ==========================================================================
  // Millisecond tick shared by blink and DTC delays
  reg [17:0] pre_q;
  reg        ms_tick_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q     <= 18'h0;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (pre_q == MS_CYCLES[17:0] - 18'h1);
      if (pre_q == MS_CYCLES[17:0] - 18'h1)
        pre_q <= 18'h0;
      else
        pre_q <= pre_q + 18'h1;
    end
  end

  // ==========================================================================
  // Per-event DTC sequencer
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
      reg  [1:0] st_q;
      reg  [7:0] cnt_q;
      reg  [6:0] occ_q;
      wire [31:0] cfg  = dtc_cfg_q[gi];
      wire       det   = fault_lvl[gi] & cfg[`DFDM_DTC_GEN] & ~diag_off;  // [R11]
      wire       latch = cfg[`DFDM_DTC_DM11_ONLY];
      wire [7:0] on_d  = cfg[`DFDM_DTC_ON_LSB+7:`DFDM_DTC_ON_LSB];
      wire [7:0] off_d = cfg[`DFDM_DTC_OFF_LSB+7:`DFDM_DTC_OFF_LSB];
      wire       go_act = (st_q == ST_PEND) && det && (cnt_q >= on_d);
      assign act_ev[gi]  = go_act;
      assign act_lvl[gi] = (st_q == ST_ACT) || (st_q == ST_CLR);
      assign occ_all[gi*7 +: 7] = occ_q;

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          st_q  <= ST_IDLE;
          cnt_q <= 8'h0;
          occ_q <= 7'h0;
        end else begin
          if (ms_tick_q && cnt_q != 8'hff)
            cnt_q <= cnt_q + 8'h1;
          case (st_q)
            ST_IDLE: begin
              cnt_q <= 8'h0;
              if (det)
                st_q <= ST_PEND;
            end
            ST_PEND: begin
              if (!det)
                st_q <= ST_IDLE;                             // [R17]
              else if (go_act)
                st_q <= ST_ACT;                              // [R17]
            end
            ST_ACT: begin
              cnt_q <= 8'h0;
              if (!det && latch && dm11)
                st_q <= ST_IDLE;                             // [R13]
              else if (!det && !latch)
                st_q <= ST_CLR;                              // [R12]
            end
            ST_CLR: begin
              if (det)
                st_q <= ST_ACT;
              else if (cnt_q >= off_d)
                st_q <= ST_IDLE;                             // [R18]
            end
            default: st_q <= ST_IDLE;
          endcase
          // A new activation outranks a DM3 in the same cycle
          if (go_act && occ_q != `DFDM_OCC_MAX)
            occ_q <= occ_q + 7'h1;                           // [R19]
          else if (go_act)
            occ_q <= occ_q;
          else if (dm3)
            occ_q <= 7'h0;                                   // [R19]
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Lamp drive with shared blink phase
  reg [15:0] blink_cnt_q;
  reg        phase_q;
  wire [7:0] src_vec = {diag_off ? 1'b0 : |fault_lvl, fault_lvl, 1'b0};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_q <= 16'h0;
      phase_q     <= 1'b0;
    end else if (ms_tick_q) begin
      if (blink_cnt_q + 16'h1 >= led_cfg_q[31:16]) begin
        blink_cnt_q <= 16'h0;
        phase_q     <= ~phase_q;                             // [R02]
      end else begin
        blink_cnt_q <= blink_cnt_q + 16'h1;
      end
    end
  end

  // LED source 0 selects a constant-false input; 7 is the global fault
  integer li;
  reg [2:0] led_d;
  reg       src_b;
  always @* begin
    led_d = 3'h0;
    src_b = 1'b0;
    for (li = 0; li < 3; li = li + 1) begin
      src_b = src_vec[led_cfg_q[6+li*3 +: 3]];
      case (led_cfg_q[li*2 +: 2])
        `DFDM_RESP_ON:    led_d[li] = src_b;                 // [R01]
        `DFDM_RESP_BLINK: led_d[li] = src_b & phase_q;       // [R01]
        default:          led_d[li] = 1'b0;                  // [R01]
      endcase
    end
  end

  // ==========================================================================
  // Registered outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_q         <= 3'h0;
      outputs_off_q <= 1'b0;
      dtc_active_q  <= 6'h0;
      empty_dm1_q   <= 1'b0;
      irq_q         <= 1'b0;
    end else begin
      led_q         <= led_d;
      outputs_off_q <= (ctrl_q[`DFDM_CTRL_PWR_SD] & sup_f) |
                       (ctrl_q[`DFDM_CTRL_TEMP_SD] & ot_q);  // [R09]
      dtc_active_q  <= act_lvl;
      empty_dm1_q   <= ctrl_q[`DFDM_CTRL_EMPTY_DM1] & ~(|act_lvl);
      irq_q         <= |(int_stat_q & int_mask_q);
    end
  end

  // ==========================================================================
  // APB writes, command pulses and sticky interrupt status
  integer ci;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `DFDM_CTRL_RST;                          // [R03]
      volt_q     <= `DFDM_VOLT_RST;
      temp_q     <= `DFDM_TEMP_RST;
      led_cfg_q  <= `DFDM_LED_RST;
      int_stat_q <= 6'h0;
      int_mask_q <= 6'h0;
      dm11_cmd_q <= 1'b0;
      dm3_cmd_q  <= 1'b0;
      for (ci = 0; ci < NCH; ci = ci + 1)
        dtc_cfg_q[ci] <= (ci == 3) ? `DFDM_DTC_MOTOR_RST : `DFDM_DTC_RST;  // [R14]
    end else begin
      dm11_cmd_q <= wr_en && paddr == `DFDM_OFF_CMD && pwdata[`DFDM_CMD_DM11];
      dm3_cmd_q  <= wr_en && paddr == `DFDM_OFF_CMD && pwdata[`DFDM_CMD_DM3];
      // Activation sets win over a same-cycle write-one clear
      if (wr_en && paddr == `DFDM_OFF_INT_STAT)
        int_stat_q <= (int_stat_q & ~pwdata[5:0]) | act_ev;
      else
        int_stat_q <= int_stat_q | act_ev;
      if (wr_en) begin
        case (paddr)
          `DFDM_OFF_CTRL:     ctrl_q     <= {26'h0, pwdata[5:0]};
          `DFDM_OFF_VOLT:     volt_q     <= {8'h0, pwdata[23:0]};
          `DFDM_OFF_TEMP:     temp_q     <= {16'h0, pwdata[15:0]};
          `DFDM_OFF_LED:      led_cfg_q  <= {pwdata[31:16], 1'b0, pwdata[14:0]};
          `DFDM_OFF_INT_MASK: int_mask_q <= pwdata[5:0];
          default: begin
            for (ci = 0; ci < NCH; ci = ci + 1)
              if (paddr == `DFDM_OFF_DTC_CFG + ci[7:0] * 8'h4)
                dtc_cfg_q[ci] <= {pwdata[31:16], 7'h0,
                                  (pwdata[8:4] > `DFDM_FMI_MAX) ? `DFDM_FMI_EXISTS
                                                                  : pwdata[8:4],  // [R16]
                                  pwdata[3:0]};                                  // [R15]
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // APB read path: one wait state, error on unmapped addresses
  reg [31:0] rd_d;
  reg        hit_d;
  integer    ri;
  always @* begin
    rd_d  = 32'h0;
    hit_d = 1'b1;
    case (paddr)
      `DFDM_OFF_CTRL:     rd_d = ctrl_q;
      `DFDM_OFF_VOLT:     rd_d = volt_q;
      `DFDM_OFF_TEMP:     rd_d = temp_q;
      `DFDM_OFF_LED:      rd_d = led_cfg_q;
      `DFDM_OFF_INT_STAT: rd_d = {26'h0, int_stat_q};
      `DFDM_OFF_INT_MASK: rd_d = {26'h0, int_mask_q};
      `DFDM_OFF_FAULT:    rd_d = {23'h0, can_q, ot_q, ov_q, uv_q, fault_lvl[5:3], 2'h0};
      `DFDM_OFF_CMD:      rd_d = 32'h0;
      default: begin
        hit_d = 1'b0;
        for (ri = 0; ri < NCH; ri = ri + 1) begin
          if (paddr == `DFDM_OFF_DTC_CFG + ri[7:0] * 8'h4) begin
            rd_d  = dtc_cfg_q[ri];
            hit_d = 1'b1;
          end
          if (paddr == `DFDM_OFF_DTC_STAT + ri[7:0] * 8'h4) begin
            rd_d  = {17'h0, occ_all[ri*7 +: 7], 7'h0, act_lvl[ri]};
            hit_d = 1'b1;
          end
        end
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~hit_d;
      prdata_q  <= (psel & penable & ~pready_q & ~pwrite) ? rd_d : 32'h0;
    end
  end

endmodule

// [sim/dfdm_chk_sva.sv]
// Port-level assertion checker for the DTC manager
`timescale 1ns/1ps
`include "dfdm_map.vh"

module dfdm_chk #(
  parameter MS_CYCLES = 10
) (
  // Clock, reset and APB
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready_q,
  // Measurements and results
  input wire [7:0]  supply_volts,
  input wire [7:0]  temp_deg,
  input wire        motor_fault,
  input wire [2:0]  led_q,
  input wire        outputs_off_q,
  input wire [5:0]  dtc_active_q,
  input wire        empty_dm1_q
);
  // ====================
  // Shadow registers
  logic [31:0] ctrl_q;
  logic [31:0] volt_q;
  logic [31:0] temp_q;
  logic [1:0]  lrsp_q;
  logic [7:0]  uv_c;
  wire         wr_ok = psel && penable && pready_q && pwrite;

  // Clamped threshold; the register itself keeps any raw value
  assign uv_c = (volt_q[7:0] < `DFDM_V_MIN) ? `DFDM_V_MIN :
                (volt_q[7:0] > `DFDM_V_MAX) ? `DFDM_V_MAX : volt_q[7:0];

  // Mirror writes at the same edge the slave takes them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `DFDM_CTRL_RST;
      volt_q <= `DFDM_VOLT_RST;
      temp_q <= `DFDM_TEMP_RST;
      lrsp_q <= 2'h0;
    end else if (wr_ok) begin
      case (paddr)
        `DFDM_OFF_CTRL: ctrl_q <= pwdata;
        `DFDM_OFF_VOLT: volt_q <= pwdata;
        `DFDM_OFF_TEMP: temp_q <= pwdata;
        `DFDM_OFF_LED:  lrsp_q <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // ====================
  // Properties, four cycles allowed for flag plus output register
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ot_sd;
    (ctrl_q[3] && ctrl_q[5] && temp_deg >= temp_q[7:0]) [*4] |-> outputs_off_q;
  endproperty
  a_ot_sd: assert property (p_ot_sd) else $error("heat did not shut outputs");
  property p_no_off;
    (!ctrl_q[4] && !ctrl_q[5]) [*4] |-> !outputs_off_q;
  endproperty
  a_no_off: assert property (p_no_off) else $error("outputs off without option");
  property p_uv_sd;
    (ctrl_q[2] && ctrl_q[4] && supply_volts < uv_c) [*4] |-> outputs_off_q;
  endproperty
  a_uv_sd: assert property (p_uv_sd) else $error("undervoltage not flagged");
  property p_ot_clr;
    (!ctrl_q[4] && {1'b0, temp_deg} + {1'b0, temp_q[15:8]} <= {1'b0, temp_q[7:0]}) [*4]
      |-> !outputs_off_q;
  endproperty
  a_ot_clr: assert property (p_ot_clr) else $error("heat fault not cleared");
  property p_no_rise;
    (!motor_fault) [*8] |-> !(dtc_active_q[3] && !$past(dtc_active_q[3]));
  endproperty
  a_no_rise: assert property (p_no_rise) else $error("motor code without fault");
  property p_quiet;
    ctrl_q[0] [*4] |-> (dtc_active_q & ~$past(dtc_active_q)) == 6'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("code raised while checks off");
  property p_empty;
    empty_dm1_q |-> $past(ctrl_q[1]);
  endproperty
  a_empty: assert property (p_empty) else $error("empty report not enabled");
  property p_led_off;
    (lrsp_q == `DFDM_RESP_OFF) [*3] |-> !led_q[0];
  endproperty
  a_led_off: assert property (p_led_off) else $error("lamp lit while set off");

  // Main scenarios reached
  c_off: cover property ($rose(outputs_off_q));
  c_dtc: cover property ($rose(dtc_active_q[3]));
  c_empty: cover property ($rose(empty_dm1_q));
endmodule

bind dfdm_top dfdm_chk #(.MS_CYCLES(MS_CYCLES)) dfdm_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready_q(pready_q), .supply_volts(supply_volts),
  .temp_deg(temp_deg), .motor_fault(motor_fault), .led_q(led_q),
  .outputs_off_q(outputs_off_q), .dtc_active_q(dtc_active_q), .empty_dm1_q(empty_dm1_q));

// [sim/dfdm_can_node.sv]
// Behavioural network node: timeouts, receptions, DM11 and DM3
`timescale 1ns/1ps

module dfdm_can_node (
  // Clock
  input  wire        pclk,
  // Events towards the block
  output logic       can_rx_timeout,
  output logic       can_rx_msg,
  output logic       dm11_rx,
  output logic       dm3_rx
);
  // ====================
  // Event pulses, idle low
  logic [3:0] ev_q = 4'h0;
  assign {dm3_rx, dm11_rx, can_rx_msg, can_rx_timeout} = ev_q;

  // One-cycle pulse; a held level would repeat the command
  task send(input int k);  // 0 timeout, 1 reception 2 DM11, 3 DM3
    @(posedge pclk);
    ev_q[k] <= 1'b1;
    @(posedge pclk);
    ev_q[k] <= 1'b0;
  endtask
endmodule

// [sim/dfdm_tb_top.sv]
// Self-checking bench for the DTC manager
`timescale 1ns/1ps
`include "dfdm_map.vh"

module dfdm_tb_top;
  // ====================
  // Stimulus and observed signals
  localparam MS = 10;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  supply_volts = 8'h18;
  logic [7:0]  temp_deg = 8'h19;
  logic        motor_fault = 1'b0;
  logic        uin_fault = 1'b0;
  logic        enc_fault = 1'b0;
  wire  [31:0] prdata_q;
  wire  [2:0]  led_q;
  wire  [5:0]  dtc_active_q;
  wire         pready_q, pslverr_q, outputs_off_q, empty_dm1_q, irq_q;
  wire         can_rx_timeout, can_rx_msg, dm11_rx, dm3_rx;
  int          fails = 0;
  int          compares = 0;
  int          hi;
  logic [31:0] rv;
  logic        re;

  // Clock toggles each half period
  always #2 pclk = ~pclk;

  dfdm_top #(.MS_CYCLES(MS)) dfdm_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
    .pslverr_q(pslverr_q), .supply_volts(supply_volts), .temp_deg(temp_deg),
    .can_rx_timeout(can_rx_timeout), .can_rx_msg(can_rx_msg), .motor_fault(motor_fault),
    .uin_fault(uin_fault), .enc_fault(enc_fault), .dm11_rx(dm11_rx), .dm3_rx(dm3_rx),
    .led_q(led_q), .outputs_off_q(outputs_off_q), .dtc_active_q(dtc_active_q),
    .empty_dm1_q(empty_dm1_q), .irq_q(irq_q));
  dfdm_can_node dfdm_can_node_inst (
    .pclk(pclk), .can_rx_timeout(can_rx_timeout), .can_rx_msg(can_rx_msg),
    .dm11_rx(dm11_rx), .dm3_rx(dm3_rx));

  // Compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // APB transfer: request held until pready is sampled high
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_q !== 1'b1) @(posedge pclk);
    rv = prdata_q;
    re = pslverr_q;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rv, e);
  endtask

  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Apply measurements, let flags settle, check shutdown
  task lvl(input logic [7:0] v, input logic [7:0] t, input logic e);
    supply_volts <= v;
    temp_deg <= t;
    wt(8);
    chk("outputs_off", 32'(outputs_off_q), 32'(e));
  endtask

  task close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog far above the expected run of several hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out;
  end

  // ====================
  // Test sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", 8'h00, `DFDM_CTRL_RST);
    rdc("volt", 8'h04, `DFDM_VOLT_RST);
    rdc("led", 8'h0c, `DFDM_LED_RST);
    for (int i = 0; i < 6; i++)
      rdc("cfg", 8'h20 + 8'(4 * i), i == 3 ? `DFDM_DTC_MOTOR_RST : `DFDM_DTC_RST);
    bus(1'b0, 8'h80, 32'h0);
    chk("slverr", 32'(re), 32'h1);
    chk("empty_dm1", 32'(empty_dm1_q), 32'h0);
    $display("reset test done");
    // Heat: threshold 100, hysteresis 5
    bus(1'b1, 8'h00, 32'h28);
    lvl(8'h18, 8'h64, 1'b1);
    rdc("fault", 8'h18, 32'h80);
    lvl(8'h18, 8'h60, 1'b1);
    lvl(8'h18, 8'h5f, 1'b0);
    lvl(8'h18, 8'h63, 1'b0);
    bus(1'b1, 8'h00, 32'h08);
    lvl(8'h18, 8'h64, 1'b0);
    $display("heat test done");
    // Supply: under 10, over 32, hysteresis 1
    bus(1'b1, 8'h00, 32'h14);
    lvl(8'h09, 8'h19, 1'b1);
    chk("dtc", 32'(dtc_active_q), 32'h0);
    lvl(8'h0a, 8'h19, 1'b1);
    lvl(8'h0b, 8'h19, 1'b0);
    lvl(8'h21, 8'h19, 1'b1);
    lvl(8'h20, 8'h19, 1'b1);
    lvl(8'h1f, 8'h19, 1'b0);
    bus(1'b1, 8'h04, 32'h0001_2005);
    rdc("volt", 8'h04, 32'h0001_2005);
    lvl(8'h08, 8'h19, 1'b1);
    lvl(8'h18, 8'h19, 1'b0);
    bus(1'b1, 8'h00, 32'h0);
    $display("supply test done");
    // Lamp and mode codes, mode above 21 reads as 31
    for (int l = 0; l < 4; l++) begin
      bus(1'b1, 8'h34, 32'h150 | 32'(l << 2));
      rdc("cfg5", 8'h34, 32'h150 | 32'(l << 2));
    end
    bus(1'b1, 8'h2c, 32'h0303_0199);
    rdc("cfg3", 8'h2c, 32'h0303_01f9);
    // Short motor fault must not activate its code
    bus(1'b1, 8'h14, 32'h8);
    motor_fault <= 1'b1;
    wt(MS);
    motor_fault <= 1'b0;
    wt(6 * MS);
    chk("dtc3", 32'(dtc_active_q), 32'h0);
    motor_fault <= 1'b1;
    bus(1'b1, 8'h0c, 32'h0001_7fc9);
    wt(6 * MS);
    chk("dtc3", 32'(dtc_active_q), 32'h8);
    chk("irq", 32'(irq_q), 32'h1);
    rdc("stat3", 8'h4c, 32'h0101);
    chk("led0", 32'(led_q[0]), 32'h1);
    chk("led2", 32'(led_q[2]), 32'h0);
    hi = 0;
    for (int i = 0; i < 4 * MS; i++) begin
      @(posedge pclk);
      hi += 32'(led_q[1]);
    end
    chk("blink", 32'(hi > MS && hi < 3 * MS), 32'h1);
    // Masking and clearing the event
    bus(1'b1, 8'h14, 32'h0);
    wt(2);
    chk("irq", 32'(irq_q), 32'h0);
    rdc("int_stat", 8'h10, 32'h8);
    bus(1'b1, 8'h10, 32'h8);
    rdc("int_stat", 8'h10, 32'h0);
    motor_fault <= 1'b0;
    wt(MS);
    chk("dtc3", 32'(dtc_active_q), 32'h8);
    wt(5 * MS);
    chk("dtc3", 32'(dtc_active_q), 32'h0);
    $display("motor test done");
    // Universal input: silent by default, then held until DM11
    uin_fault <= 1'b1;
    wt(2 * MS);
    chk("dtc4", 32'(dtc_active_q), 32'h0);
    bus(1'b1, 8'h30, 32'h3);
    wt(2 * MS);
    chk("dtc4", 32'(dtc_active_q), 32'h10);
    dfdm_can_node_inst.send(2);
    wt(4);
    chk("dtc4", 32'(dtc_active_q), 32'h10);
    uin_fault <= 1'b0;
    wt(3 * MS);
    chk("dtc4", 32'(dtc_active_q), 32'h10);
    dfdm_can_node_inst.send(2);
    wt(4);
    chk("dtc4", 32'(dtc_active_q), 32'h0);
    rdc("stat4", 8'h50, 32'h0100);
    dfdm_can_node_inst.send(3);
    wt(4);
    rdc("stat4", 8'h50, 32'h0);
    $display("latch test done");
    // Receive timeout raises a code, the next reception clears it
    bus(1'b1, 8'h28, 32'h1);
    dfdm_can_node_inst.send(0);
    wt(2 * MS);
    chk("dtc2", 32'(dtc_active_q), 32'h4);
    dfdm_can_node_inst.send(1);
    wt(2 * MS);
    chk("dtc2", 32'(dtc_active_q), 32'h0);
    // Encoder fault is visible but raises no code by default
    enc_fault <= 1'b1;
    wt(2 * MS);
    chk("dtc5", 32'(dtc_active_q), 32'h0);
    rdc("fault", 8'h18, 32'h10);
    enc_fault <= 1'b0;
    // Checks switched off, empty report requested
    bus(1'b1, 8'h00, 32'h3);
    motor_fault <= 1'b1;
    wt(6 * MS);
    chk("dtc3", 32'(dtc_active_q), 32'h0);
    chk("empty_dm1", 32'(empty_dm1_q), 32'h1);
    $display("network test done");
    close_out;
  end
endmodule
